/* logic/rtc_irq_clkout.sv */
// Operation
// - alarm enable bit 1 arms its alarm, 0 disables it
// - alarm flag read returns the current alarm interrupt state
// - flag write 1 ignored; write 0 clears flag and releases pin
// - clearing a flag leaves the enable set; alarm fires at next match
// - week alarm compares day, hour, minute; daily alarm hour, minute
// - period select 000 keeps output high, 001 holds it low
// - select 010 gives 2 Hz, 011 gives 1 Hz, half duty, second aligned
// - pulse mode: second increments about 92 us after the falling edge
// - second counter write resets sub-second divider, periodic output low
// - level mode: low at each period until periodic flag written 0
// - select 100: level interrupt every second, at second increment
// - select 101: level interrupt every minute at seconds zero
// - select 110: level interrupt every hour at minutes, seconds zero
// - select 111: level interrupt monthly at midnight of day one
// - adjustment changes one cycle every 20 s by at most 3.784 ms
// - clock out runs when pin high and either enable_n bit is 0
// - clock out starts and stops without truncated pulses
// - week alarm drives second pin; daily and periodic share first
// - first pin is low when either of its sources is asserted
//
// Chosen here: the APB register port and the register offsets.
module rtc_irq_clkout (
   input wire logic clk_sys, // system clock, 25 MHz
   input wire logic nrst, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic osc_32k, // 32.768 kHz oscillator pin
   input wire logic clkout_control_pin, // clock output control pin
   output logic slow_clock_out_pin, // gated 32.768 kHz output
   input wire logic [7:0] time_sec, // bcd seconds from time counters
   input wire logic [7:0] time_min, // bcd minutes
   input wire logic [7:0] time_hour, // bcd hours
   input wire logic [2:0] time_wday, // day of week 0..6
   input wire logic [7:0] time_mday, // bcd day of month
   input wire logic sec_write, // pulse: second counter written
   output logic sec_inc, // pulse: advance the second counter
   output logic irq_first_n_o, // first interrupt pin drive value
   output logic irq_first_n_oe_n, // first pin enable, low = pulling low
   output logic irq_second_n_o, // second interrupt pin drive value
   output logic irq_second_n_oe_n // second pin enable, low = pulling low
);
   // ----------------------------------------------------------------
   // apb slave and registers
   // ----------------------------------------------------------------
   logic week_en_q, daily_en_q, clken_n2_q, clken_n1_q;
   logic [2:0] sel_q;
   logic week_flag_q, daily_flag_q, pflag_q;
   logic [6:0] wa_wday_q;
   logic [7:0] wa_hour_q, wa_min_q, da_hour_q, da_min_q;
   logic [7:0] adj_q;
   logic [31:0] prdata_q;
   logic wr_en, setup, hit;
   logic week_set, daily_set, pflag_set;

   // zero wait states: read data is latched in the setup cycle
   assign pready = 1'b1;
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite;
   assign hit = (paddr == rtc_pkg::OFF_CTRL1) || (paddr == rtc_pkg::OFF_CTRL2) ||
                (paddr == rtc_pkg::OFF_WALARM) || (paddr == rtc_pkg::OFF_DALARM) ||
                (paddr == rtc_pkg::OFF_ADJUST);
   assign pslverr = psel & penable & ~hit;
   assign prdata = prdata_q;

   // control register 1 and adjustment
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         {week_en_q, daily_en_q} <= 2'h0;
         clken_n2_q <= 1'b0;
         sel_q <= rtc_pkg::SEL_OFF;
         adj_q <= rtc_pkg::RST_ADJUST;
      end else if (wr_en && paddr == rtc_pkg::OFF_CTRL1) begin
         week_en_q <= pwdata[rtc_pkg::BIT_WEEK_EN];
         daily_en_q <= pwdata[rtc_pkg::BIT_DAILY_EN];
         clken_n2_q <= pwdata[rtc_pkg::BIT_CLKEN_N2];
         sel_q <= pwdata[rtc_pkg::SEL_LSB +: 3];
      end else if (wr_en && paddr == rtc_pkg::OFF_ADJUST) begin
         adj_q <= pwdata[7:0];
      end
   end

   // alarm time registers
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wa_wday_q <= 7'h00;
         {wa_hour_q, wa_min_q, da_hour_q, da_min_q} <= 32'h0;
      end else if (wr_en && paddr == rtc_pkg::OFF_WALARM) begin
         wa_wday_q <= pwdata[rtc_pkg::AL_WDAY_LSB +: 7];
         wa_hour_q <= pwdata[rtc_pkg::AL_HOUR_LSB +: 8];
         wa_min_q <= pwdata[rtc_pkg::AL_MIN_LSB +: 8];
      end else if (wr_en && paddr == rtc_pkg::OFF_DALARM) begin
         da_hour_q <= pwdata[rtc_pkg::AL_HOUR_LSB +: 8];
         da_min_q <= pwdata[rtc_pkg::AL_MIN_LSB +: 8];
      end
   end

   // control register 2: flags only clear on 0, a same-cycle set wins
   logic c2_wr;
   assign c2_wr = wr_en && paddr == rtc_pkg::OFF_CTRL2;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         {clken_n1_q, pflag_q, week_flag_q, daily_flag_q} <= rtc_pkg::RST_CTRL2;
      end else begin
         if (c2_wr) begin
            clken_n1_q <= pwdata[rtc_pkg::BIT_CLKEN_N1];
         end
         if (week_set) begin
            week_flag_q <= 1'b1;
         end else if (c2_wr && !pwdata[rtc_pkg::BIT_WFLAG]) begin
            week_flag_q <= 1'b0;
         end
         if (daily_set) begin
            daily_flag_q <= 1'b1;
         end else if (c2_wr && !pwdata[rtc_pkg::BIT_DFLAG]) begin
            daily_flag_q <= 1'b0;
         end
         if (pflag_set) begin
            pflag_q <= 1'b1;
         end else if (c2_wr && !pwdata[rtc_pkg::BIT_PFLAG]) begin
            pflag_q <= 1'b0;
         end
      end
   end

   // read mux, sampled in the setup cycle
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prdata_q <= 32'h0;
      end else if (setup && !pwrite) begin
         case (paddr)
            rtc_pkg::OFF_CTRL1: prdata_q <= {24'h0, week_en_q, daily_en_q, 1'b0,
                                             clken_n2_q, 1'b0, sel_q};
            // flags read as the live interrupt state
            rtc_pkg::OFF_CTRL2: prdata_q <= {28'h0, clken_n1_q, pflag_q,
                                             week_flag_q, daily_flag_q};
            rtc_pkg::OFF_WALARM: prdata_q <= {9'h0, wa_wday_q, wa_hour_q, wa_min_q};
            rtc_pkg::OFF_DALARM: prdata_q <= {16'h0, da_hour_q, da_min_q};
            rtc_pkg::OFF_ADJUST: prdata_q <= {24'h0, adj_q};
            default: prdata_q <= 32'h0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers and slow tick
   // ----------------------------------------------------------------
   logic [1:0] osc_sync_q, ctl_sync_q;
   logic osc_prev_q;
   logic tick, osc_fall;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         osc_sync_q <= 2'h0;
         ctl_sync_q <= 2'h0;
         osc_prev_q <= 1'b0;
      end else begin
         osc_sync_q <= {osc_sync_q[0], osc_32k};
         ctl_sync_q <= {ctl_sync_q[0], clkout_control_pin};
         osc_prev_q <= osc_sync_q[1];
      end
   end
   assign tick = osc_sync_q[1] & ~osc_prev_q;
   assign osc_fall = ~osc_sync_q[1] & osc_prev_q;

   // ----------------------------------------------------------------
   // sub-second divider with adjustment
   // ----------------------------------------------------------------
   logic [14:0] div_q;
   logic [4:0] sec_cnt_q;
   logic [7:0] stall_q;
   logic sec_inc_q;
   logic [8:0] adj_mag;
   logic [7:0] adj_lim;
   logic adj_sec, wrap;
   logic [14:0] wrap_at;

   // magnitude clamped so one cycle never moves by more than the limit
   assign adj_mag = adj_q[7] ? 9'(-{adj_q[7], adj_q}) : {1'b0, adj_q};
   assign adj_lim = (adj_mag > 9'(rtc_pkg::ADJ_MAX_TICKS)) ?
                    8'(rtc_pkg::ADJ_MAX_TICKS) : adj_mag[7:0];
   assign adj_sec = sec_cnt_q == 5'(rtc_pkg::ADJ_PERIOD_SEC - 1);
   // shortening ends the adjusted second early
   assign wrap_at = (adj_sec && !adj_q[7]) ? 15'(rtc_pkg::DIV_LAST - adj_lim) :
                    rtc_pkg::DIV_LAST;
   assign wrap = tick && stall_q == 8'h0 && div_q >= wrap_at;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         div_q <= 15'h0;
         sec_cnt_q <= 5'h0;
         stall_q <= 8'h0;
      end else if (sec_write) begin
         div_q <= 15'h0;
         stall_q <= 8'h0;
      end else if (tick) begin
         if (stall_q != 8'h0) begin
            stall_q <= stall_q - 8'h1; // lengthened low period
         end else if (wrap) begin
            div_q <= 15'h0;
            sec_cnt_q <= adj_sec ? 5'h0 : sec_cnt_q + 5'h1;
            stall_q <= (adj_sec && adj_q[7]) ? adj_lim : 8'h0;
         end else begin
            div_q <= div_q + 15'h1;
         end
      end
   end

   // the second advances a few ticks after the divider wraps
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sec_inc_q <= 1'b0;
      end else begin
         sec_inc_q <= tick && stall_q == 8'h0 && !sec_write &&
                      div_q == 15'(rtc_pkg::PULSE_DELAY_TICKS - 1);
      end
   end
   assign sec_inc = sec_inc_q;

   // ----------------------------------------------------------------
   // periodic interrupt
   // ----------------------------------------------------------------
   logic sec_inc_d_q, per_low;
   // time counters show the new second one cycle after the increment
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sec_inc_d_q <= 1'b0;
      end else begin
         sec_inc_d_q <= sec_inc_q;
      end
   end

   always_comb begin
      pflag_set = 1'b0;
      case (sel_q)
         rtc_pkg::SEL_SEC: pflag_set = sec_inc_q;
         rtc_pkg::SEL_MIN: pflag_set = sec_inc_d_q && time_sec == rtc_pkg::BCD_ZERO;
         rtc_pkg::SEL_HOUR: pflag_set = sec_inc_d_q && time_sec == rtc_pkg::BCD_ZERO &&
                                        time_min == rtc_pkg::BCD_ZERO;
         rtc_pkg::SEL_MONTH: pflag_set = sec_inc_d_q && time_sec == rtc_pkg::BCD_ZERO &&
                                         time_min == rtc_pkg::BCD_ZERO &&
                                         time_hour == rtc_pkg::BCD_ZERO &&
                                         time_mday == rtc_pkg::BCD_ONE;
         default: pflag_set = 1'b0;
      endcase
   end

   // pulse waveforms are low in the first half of each cycle
   always_comb begin
      per_low = 1'b0;
      case (sel_q)
         rtc_pkg::SEL_OFF: per_low = 1'b0;
         rtc_pkg::SEL_LOW: per_low = 1'b1;
         rtc_pkg::SEL_2HZ: per_low = ~div_q[13];
         rtc_pkg::SEL_1HZ: per_low = ~div_q[14];
         default: per_low = pflag_q;
      endcase
   end

   // ----------------------------------------------------------------
   // alarms
   // ----------------------------------------------------------------
   logic week_match, daily_match, week_prev_q, daily_prev_q;
   assign week_match = wa_wday_q[time_wday] && wa_hour_q == time_hour &&
                       wa_min_q == time_min;
   assign daily_match = da_hour_q == time_hour && da_min_q == time_min;
   // only a new match sets the flag, so a cleared flag waits for the next one
   assign week_set = week_en_q && week_match && !week_prev_q;
   assign daily_set = daily_en_q && daily_match && !daily_prev_q;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         week_prev_q <= 1'b0;
         daily_prev_q <= 1'b0;
      end else begin
         week_prev_q <= week_match;
         daily_prev_q <= daily_match;
      end
   end

   // ----------------------------------------------------------------
   // open-drain pins, drive value fixed low
   // ----------------------------------------------------------------
   logic first_oe_n_q, second_oe_n_q;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         first_oe_n_q <= 1'b1;
         second_oe_n_q <= 1'b1;
      end else begin
         first_oe_n_q <= ~((daily_flag_q & daily_en_q) | per_low);
         second_oe_n_q <= ~(week_flag_q & week_en_q);
      end
   end
   assign irq_first_n_o = 1'b0;
   assign irq_second_n_o = 1'b0;
   assign irq_first_n_oe_n = first_oe_n_q;
   assign irq_second_n_oe_n = second_oe_n_q;

   // ----------------------------------------------------------------
   // 32 kHz output gating
   // ----------------------------------------------------------------
   logic gate_q, clk_out_q;
   // gate only changes while the oscillator is low: no short pulses
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         gate_q <= 1'b0;
      end else if (osc_fall) begin
         gate_q <= ctl_sync_q[1] & ~(clken_n1_q & clken_n2_q);
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         clk_out_q <= 1'b0;
      end else begin
         clk_out_q <= gate_q & osc_sync_q[1];
      end
   end
   assign slow_clock_out_pin = clk_out_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence low_sel_s;
      (sel_q == rtc_pkg::SEL_LOW) [*2];
   endsequence

   flag_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (c2_wr && !pwdata[rtc_pkg::BIT_DFLAG] && !daily_set) |=> !daily_flag_q)
      else $error("daily flag not cleared by write 0");
   flag_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      week_set |=> week_flag_q ##1 !second_oe_n_q)
      else $error("week alarm did not set flag and pin");
   enable_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      c2_wr |=> $stable(week_en_q) && $stable(daily_en_q))
      else $error("enable changed by flag write");
   low_fixed_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      low_sel_s |-> !first_oe_n_q)
      else $error("select 001 did not hold pin low");
   sec_reset_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      sec_write |=> div_q == 15'h0 ##1 (sel_q != rtc_pkg::SEL_1HZ || !first_oe_n_q))
      else $error("second write did not reset divider");
   inc_delay_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      sec_inc_q |-> div_q == 15'(rtc_pkg::PULSE_DELAY_TICKS) && stall_q == 8'h0)
      else $error("second increment at wrong divider phase");
   level_sec_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (sel_q == rtc_pkg::SEL_SEC && sec_inc_q) |=> pflag_q ##1 !first_oe_n_q)
      else $error("level interrupt missed second");
   clk_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      !gate_q |=> !clk_out_q)
      else $error("clock output ran while gated");
   adj_bound_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      stall_q <= 8'(rtc_pkg::ADJ_MAX_TICKS))
      else $error("adjustment beyond limit");
endmodule : rtc_irq_clkout

/* logic/rtc_pkg.sv */
package rtc_pkg;
   // ----------------------------------------------------------------
   // register map (byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL1 = 8'h00;
   localparam logic [7:0] OFF_CTRL2 = 8'h04;
   localparam logic [7:0] OFF_WALARM = 8'h08;
   localparam logic [7:0] OFF_DALARM = 8'h0c;
   localparam logic [7:0] OFF_ADJUST = 8'h10;
   // ctrl1 fields
   localparam int BIT_WEEK_EN = 7;
   localparam int BIT_DAILY_EN = 6;
   localparam int BIT_CLKEN_N2 = 4;
   localparam int SEL_LSB = 0;
   // ctrl2 fields
   localparam int BIT_CLKEN_N1 = 3;
   localparam int BIT_PFLAG = 2;
   localparam int BIT_WFLAG = 1;
   localparam int BIT_DFLAG = 0;
   // alarm fields
   localparam int AL_MIN_LSB = 0;
   localparam int AL_HOUR_LSB = 8;
   localparam int AL_WDAY_LSB = 16;
   // reset values
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [3:0] RST_CTRL2 = 4'h0;
   localparam logic [7:0] RST_ADJUST = 8'h00;
   // period select codes
   localparam logic [2:0] SEL_OFF = 3'h0;
   localparam logic [2:0] SEL_LOW = 3'h1;
   localparam logic [2:0] SEL_2HZ = 3'h2;
   localparam logic [2:0] SEL_1HZ = 3'h3;
   localparam logic [2:0] SEL_SEC = 3'h4;
   localparam logic [2:0] SEL_MIN = 3'h5;
   localparam logic [2:0] SEL_HOUR = 3'h6;
   localparam logic [2:0] SEL_MONTH = 3'h7;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int SYS_CLK_HZ = 25000000;
   localparam int SLOW_HZ = 32768;
   localparam int PULSE_DELAY_US = 92;
   localparam int PULSE_DELAY_TICKS = (PULSE_DELAY_US * SLOW_HZ + 500000) / 1000000;
   localparam int ADJ_MAX_US = 3784;
   localparam int ADJ_MAX_TICKS = (ADJ_MAX_US * SLOW_HZ) / 1000000;
   localparam int ADJ_PERIOD_SEC = 20;
   localparam logic [14:0] DIV_LAST = 15'h7fff;
   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] BCD_ONE = 8'h01;
endpackage : rtc_pkg

/* test/rtc_far_model.sv */
// ------------------------------------------------------------
// far side: time counters and pulled-up interrupt lines
// ------------------------------------------------------------
module rtc_far_model (
   input wire logic clk_sys, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic sec_inc, // advance one second
   input wire logic load, // preset the counters
   input wire logic [7:0] ld_sec, // preset seconds, bcd
   input wire logic [7:0] ld_min, // preset minutes, bcd
   input wire logic [7:0] ld_hour, // preset hours, bcd
   input wire logic [2:0] ld_wday, // preset day of week
   input wire logic [7:0] ld_mday, // preset day of month, bcd
   input wire logic first_o, // first pin drive value
   input wire logic first_oe_n, // first pin enable, low drives
   input wire logic second_o, // second pin drive value
   input wire logic second_oe_n, // second pin enable, low drives
   output logic [7:0] time_sec, // seconds, bcd
   output logic [7:0] time_min, // minutes, bcd
   output logic [7:0] time_hour, // hours, bcd
   output logic [2:0] time_wday, // day of week
   output logic [7:0] time_mday, // day of month, bcd
   output logic irq_first_n, // first pin as the host sees it
   output logic irq_second_n // second pin as the host sees it
);
   timeunit 1ns;
   timeprecision 1ns;

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
   endfunction : bcd_inc

   // counters step only on the block's request; day of month is held
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         time_sec <= 8'h00;
         time_min <= 8'h00;
         time_hour <= 8'h00;
         time_wday <= 3'h0;
         time_mday <= 8'h01;
      end else if (load) begin
         time_sec <= ld_sec;
         time_min <= ld_min;
         time_hour <= ld_hour;
         time_wday <= ld_wday;
         time_mday <= ld_mday;
      end else if (sec_inc) begin
         time_sec <= (time_sec == 8'h59) ? 8'h00 : bcd_inc(time_sec);
         if (time_sec == 8'h59) begin
            time_min <= (time_min == 8'h59) ? 8'h00 : bcd_inc(time_min);
            if (time_min == 8'h59) begin
               time_hour <= (time_hour == 8'h23) ? 8'h00 : bcd_inc(time_hour);
            end
         end
      end
   end

   // released lines float up through the board pull-ups
   assign irq_first_n = first_oe_n ? 1'b1 : first_o;
   assign irq_second_n = second_oe_n ? 1'b1 : second_o;
endmodule : rtc_far_model

/* test/test_rtc_irq_clkout.sv */
module test_rtc_irq_clkout;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, nrst, psel, penable, pwrite, osc_32k, clkout_control_pin, sec_write, load;
   logic [7:0] paddr, ld_sec, ld_min, ld_hour, ld_mday, time_sec, time_min, time_hour, time_mday;
   logic [2:0] ld_wday, time_wday;
   logic [1:0] osc_div;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, slow_clock_out_pin, sec_inc, irq_first_n, irq_second_n;
   logic f_o, f_oe_n, s_o, s_oe_n;
   int miscompares, total_checks, cycles, bad_runs, run_len, n;

   rtc_irq_clkout dut_u (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .osc_32k(osc_32k), .clkout_control_pin(clkout_control_pin),
      .slow_clock_out_pin(slow_clock_out_pin), .time_sec(time_sec), .time_min(time_min),
      .time_hour(time_hour), .time_wday(time_wday), .time_mday(time_mday),
      .sec_write(sec_write), .sec_inc(sec_inc), .irq_first_n_o(f_o), .irq_first_n_oe_n(f_oe_n),
      .irq_second_n_o(s_o), .irq_second_n_oe_n(s_oe_n));

   rtc_far_model far_u (.clk_sys(clk_sys), .nrst(nrst), .sec_inc(sec_inc), .load(load),
      .ld_sec(ld_sec), .ld_min(ld_min), .ld_hour(ld_hour), .ld_wday(ld_wday), .ld_mday(ld_mday),
      .first_o(f_o), .first_oe_n(f_oe_n), .second_o(s_o), .second_oe_n(s_oe_n),
      .time_sec(time_sec), .time_min(time_min), .time_hour(time_hour), .time_wday(time_wday),
      .time_mday(time_mday), .irq_first_n(irq_first_n), .irq_second_n(irq_second_n));

   // ------------------------------------------------------------
   // clocks, timeout and pulse-width monitor
   // ------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // fast stand-in oscillator, 4 clocks a period, keeps the run short
   always @(posedge clk_sys) begin
      osc_div <= osc_div + 2'h1;
      osc_32k <= osc_div[1];
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         miscompares++;
         close_out();
      end
   end

   // any high run other than one full oscillator half is a clipped pulse
   always @(posedge clk_sys) begin
      if (slow_clock_out_pin === 1'b1) begin
         run_len <= run_len + 1;
      end else begin
         if (run_len != 0 && run_len != 2) bad_runs <= bad_runs + 1;
         run_len <= 0;
      end
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask : rd_chk

   task automatic set_time(input logic [7:0] h, m, s, input logic [2:0] wd, input logic [7:0] md);
      @(posedge clk_sys);
      load <= 1'b1;
      {ld_hour, ld_min, ld_sec, ld_wday, ld_mday} <= {h, m, s, wd, md};
      @(posedge clk_sys);
      load <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask : set_time

   // second counter write, then measure the delay to the increment request
   task automatic sec_wr();
      @(posedge clk_sys);
      sec_write <= 1'b1;
      @(posedge clk_sys);
      sec_write <= 1'b0;
      n = 0;
      while (sec_inc !== 1'b1 && n < 200) begin
         @(posedge clk_sys);
         n++;
      end
      chk(32'(n > 8 && n < 25), 32'h1);
   endtask : sec_wr

   task automatic lvl(input logic [2:0] sel, input logic [7:0] h, m, s, md, input logic e);
      wr(rtc_pkg::OFF_CTRL1, {29'h0, sel});
      set_time(h, m, s, 3'h1, md);
      sec_wr();
      repeat (4) @(posedge clk_sys);
      chk(irq_first_n, {31'h0, ~e});
      rd_chk(rtc_pkg::OFF_CTRL2, 32'h4, {29'h0, e, 2'h0});
      chk(irq_first_n, {31'h0, ~e});
      wr(rtc_pkg::OFF_CTRL2, 32'h0);
      repeat (3) @(posedge clk_sys);
      chk(irq_first_n, 1'b1);
   endtask : lvl

   task automatic clk_case(input logic pin, input logic en1, input logic en2, input logic e);
      int p;
      clkout_control_pin <= pin;
      wr(rtc_pkg::OFF_CTRL2, {28'h0, en1, 3'h0});
      wr(rtc_pkg::OFF_CTRL1, {27'h0, en2, 4'h0});
      repeat (16) @(posedge clk_sys);
      p = 0;
      repeat (64) begin
         @(posedge clk_sys);
         if (slow_clock_out_pin === 1'b1 && run_len == 0) p++;
      end
      chk(32'(p > 8), {31'h0, e});
   endtask : clk_case

   task automatic close_out();
      $display("checks %0d, miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {nrst, psel, penable, pwrite, sec_write, load, osc_32k, osc_div} = '0;
      {paddr, pwdata, ld_sec, ld_min, ld_hour, ld_wday, ld_mday} = '0;
      {miscompares, total_checks, cycles, bad_runs, run_len} = '0;
      clkout_control_pin = 1'b1;
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      for (int a = 0; a <= 16; a += 4) rd_chk(8'(a), 32'hffffffff, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, err}, 32'h1);
      // alarms: disable, program, then arm
      wr(rtc_pkg::OFF_CTRL1, 32'h0);
      wr(rtc_pkg::OFF_WALARM, 32'h00081230);
      wr(rtc_pkg::OFF_DALARM, 32'h00001230);
      wr(rtc_pkg::OFF_CTRL1, 32'hc0);
      set_time(8'h12, 8'h30, 8'h00, 3'h2, 8'h01);
      chk(irq_first_n, 1'b0);
      chk(irq_second_n, 1'b1);
      rd_chk(rtc_pkg::OFF_CTRL2, 32'h3, 32'h1);
      wr(rtc_pkg::OFF_CTRL2, 32'h7);
      rd_chk(rtc_pkg::OFF_CTRL2, 32'h3, 32'h1);
      wr(rtc_pkg::OFF_CTRL2, 32'h0);
      repeat (3) @(posedge clk_sys);
      chk(irq_first_n, 1'b1);
      rd_chk(rtc_pkg::OFF_CTRL1, 32'hff, 32'hc0);
      set_time(8'h12, 8'h31, 8'h00, 3'h2, 8'h01);
      set_time(8'h12, 8'h30, 8'h00, 3'h3, 8'h01);
      chk({irq_first_n, irq_second_n}, 2'b00);
      rd_chk(rtc_pkg::OFF_CTRL2, 32'h3, 32'h3);
      wr(rtc_pkg::OFF_CTRL1, 32'h0);
      repeat (3) @(posedge clk_sys);
      chk({irq_first_n, irq_second_n}, 2'b11);
      wr(rtc_pkg::OFF_CTRL2, 32'h0);
      wr(rtc_pkg::OFF_CTRL1, {29'h0, rtc_pkg::SEL_LOW});
      repeat (3) @(posedge clk_sys);
      chk(irq_first_n, 1'b0);
      // level modes; minute, hour and month each with a case that must stay quiet
      lvl(rtc_pkg::SEL_SEC, 8'h12, 8'h00, 8'h10, 8'h01, 1'b1);
      lvl(rtc_pkg::SEL_MIN, 8'h12, 8'h00, 8'h59, 8'h01, 1'b1);
      lvl(rtc_pkg::SEL_MIN, 8'h12, 8'h00, 8'h10, 8'h01, 1'b0);
      lvl(rtc_pkg::SEL_HOUR, 8'h12, 8'h59, 8'h59, 8'h01, 1'b1);
      lvl(rtc_pkg::SEL_HOUR, 8'h12, 8'h58, 8'h59, 8'h01, 1'b0);
      lvl(rtc_pkg::SEL_MONTH, 8'h23, 8'h59, 8'h59, 8'h01, 1'b1);
      lvl(rtc_pkg::SEL_MONTH, 8'h23, 8'h59, 8'h59, 8'h02, 1'b0);
      // pulse mode: low after the second write, high half way to 2 Hz period
      wr(rtc_pkg::OFF_CTRL1, {29'h0, rtc_pkg::SEL_2HZ});
      sec_wr();
      chk(irq_first_n, 1'b0);
      n = 0;
      while (irq_first_n !== 1'b1 && n < 40000) begin
         @(posedge clk_sys);
         n++;
      end
      chk(32'(n > 32720 && n < 32800), 32'h1);
      wr(rtc_pkg::OFF_CTRL1, {29'h0, rtc_pkg::SEL_1HZ});
      repeat (3) @(posedge clk_sys);
      chk(irq_first_n, 1'b0);
      // clock output gating by pin and both enable_n bits
      clk_case(1'b1, 1'b0, 1'b0, 1'b1);
      clk_case(1'b1, 1'b1, 1'b0, 1'b1);
      clk_case(1'b1, 1'b0, 1'b1, 1'b1);
      clk_case(1'b1, 1'b1, 1'b1, 1'b0);
      clk_case(1'b0, 1'b0, 1'b0, 1'b0);
      clk_case(1'b1, 1'b0, 1'b0, 1'b1);
      chk(32'(bad_runs), 32'h0);
      close_out();
   end
endmodule : test_rtc_irq_clkout
